// ==== ssp_check.sv ====
// Function
// - access outside its segment raises the segment-bound trap
// - same segment: skip page, group and size bits, compare the rest
// - every access must share the segment of the latest base
// - indirect pointer checked against base, then fetched pointer is new base
// - bounds checked only on real accesses, not on base setup
// - invalid group entry: absent-group or descriptor-absent trap
// - group entry page-table-base is a singleword physical address
// - write above the write ring limit is a permission trap
// - fetch above execute ring limit traps; cross-ring call is exempt
// - read above the read ring limit is a permission trap
// - invalid page entry raises the absent-page trap
// - loading a valid page into the map cache sets used
// - marking a cached page written sets modified
// - physical frame number is upper 22 physical address bits
// - permitted access is group access AND page access
// - access bits grant write, execute and read separately
// - io-only pages accept io instructions only, still under read/write bits
// - page is 4096 quarterwords, low 12 bits pick one
// - access allowed only when level is at most the ring limit; a cross-ring call skips the execute limit
`include "ssp_map.svh"

module ssp_check (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire ssp_pkg::ssp_req_t req_i,
  input wire ssp_pkg::ssp_pe_upd_t pe_upd_i,
  output logic res_valid_o,
  output ssp_pkg::ssp_trap_t res_trap_o,
  output logic [`SSP_PA_W-1:0] res_phys_o,
  output logic [`SSP_PA_W-1:0] res_pt_addr_o,
  output logic pe_wb_valid_o,
  output logic [`SSP_PE_W-1:0] pe_wb_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  localparam int VA_W = `SSP_VA_W;

  logic [1:0] ctrl_reg;
  logic [5:0] status_reg;
  logic [5:0] status_next;
  logic [VA_W-1:0] base_va_reg;
  logic [`SSP_SIZE_W-1:0] base_size_reg;
  logic base_valid_reg;
  ssp_pkg::ssp_trap_t last_trap_reg;
  logic [VA_W-1:0] trap_va_reg;
  logic ack_reg;
  logic bus_req;
  logic wr_fire;
  logic [2:0] reg_idx;

  logic same_seg;
  logic bound_ok;
  logic is_check;
  ssp_pkg::ssp_kind_t eff_kind;
  ssp_pkg::ssp_trap_t raw_trap;
  ssp_pkg::ssp_trap_t trap_now;

  // an indirect fetch reads the pointer word
  assign eff_kind = (req_i.op == ssp_pkg::ssp_op_indirect) ? ssp_pkg::ssp_kind_read
                                                           : req_i.kind;
  assign is_check = req_i.valid && (req_i.op != ssp_pkg::ssp_op_base);

  ssp_seg_match #(
    .VA_W(VA_W)
  ) u_seg (
    .base_i(base_va_reg),
    .addr_i(req_i.va),
    .size_i(base_size_reg),
    .same_o(same_seg)
  );

  // bound trap source
  // no base yet means nothing to compare against, so no bound trap
  assign bound_ok = same_seg || !base_valid_reg;

  ssp_perm_check u_perm (
    .ge_i(req_i.group_entry),
    .pe_i(req_i.page_entry),
    .kind_i(eff_kind),
    .vlevel_i(req_i.vlevel),
    .io_instr_i(req_i.io_instr),
    .in_dseg_i(req_i.in_dseg),
    .bound_ok_i(bound_ok),
    .trap_o(raw_trap)
  );

  // checking can be switched off by software for table bring-up
  assign trap_now = (is_check && ctrl_reg[`SSP_CTRL_CHECK]) ? raw_trap
                                                            : ssp_pkg::ssp_trap_none;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      base_va_reg <= '0;
      base_size_reg <= `SSP_SIZE_MIN;
      base_valid_reg <= 1'b0;
    end else if (req_i.valid && (req_i.op == ssp_pkg::ssp_op_base ||
                 (req_i.op == ssp_pkg::ssp_op_indirect &&
                  trap_now == ssp_pkg::ssp_trap_none))) begin
      base_va_reg <= req_i.new_base;
      base_size_reg <= req_i.new_size;
      base_valid_reg <= 1'b1;
    end
  end

  // result stage, one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      res_valid_o <= 1'b0;
      res_trap_o <= ssp_pkg::ssp_trap_none;
      res_phys_o <= '0;
      res_pt_addr_o <= '0;
    end else begin
      res_valid_o <= req_i.valid;
      if (req_i.valid) begin
        res_trap_o <= trap_now;
        res_phys_o <= {req_i.page_entry[`SSP_PE_PFN_LSB +: `SSP_PFN_W],
                       req_i.va[`SSP_PAGE_BITS-1:0]};
        res_pt_addr_o <= {req_i.group_entry[`SSP_GE_PTB_LSB +: `SSP_GE_PTB_W], 2'b00};
      end
    end
  end

  // used and modified flags
  // invalid entries belong to software, so they are never written back
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pe_wb_valid_o <= 1'b0;
      pe_wb_o <= '0;
    end else begin
      pe_wb_valid_o <= pe_upd_i.valid && pe_upd_i.entry[`SSP_PE_VALID] &&
                       ctrl_reg[`SSP_CTRL_UPDATE];
      if (pe_upd_i.valid) begin
        pe_wb_o <= pe_upd_i.entry;
        pe_wb_o[`SSP_PE_USED] <= 1'b1;
        pe_wb_o[`SSP_PE_MOD] <= pe_upd_i.entry[`SSP_PE_MOD] | pe_upd_i.mark_written;
      end
    end
  end

  // bus slave: one wait cycle, then the access completes
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign wr_fire = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign reg_idx = avs_address_i[4:2];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // read data is latched in the wait cycle and stands at completion
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack_reg) begin
      case (reg_idx)
        `SSP_REG_CTRL: avs_readdata_o <= {30'h0, ctrl_reg};
        `SSP_REG_STATUS: avs_readdata_o <= {26'h0, status_reg};
        `SSP_REG_BASE: avs_readdata_o <= {base_valid_reg, base_va_reg};
        `SSP_REG_TRAP: avs_readdata_o <= {19'h0, base_size_reg, 5'h0, last_trap_reg};
        `SSP_REG_TRAP_VA: avs_readdata_o <= {1'b0, trap_va_reg};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // control bits
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SSP_CTRL_RST;
    end else if (wr_fire && reg_idx == `SSP_REG_CTRL) begin
      ctrl_reg <= avs_writedata_i[1:0];
    end
  end

  // sticky trap flags, write one to clear; a new trap wins over the clear
  always_comb begin
    status_next = status_reg;
    if (wr_fire && reg_idx == `SSP_REG_STATUS) begin
      status_next = status_next & ~avs_writedata_i[5:0];
    end
    if (res_valid_o && res_trap_o != ssp_pkg::ssp_trap_none) begin
      status_next[res_trap_o] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // last trap and its address for software diagnosis
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_trap_reg <= ssp_pkg::ssp_trap_none;
      trap_va_reg <= '0;
    end else if (req_i.valid && trap_now != ssp_pkg::ssp_trap_none) begin
      last_trap_reg <= trap_now;
      trap_va_reg <= req_i.va;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic gv;
  logic pv;
  logic [1:0] lvl;
  assign gv = req_i.group_entry[`SSP_GE_VALID];
  assign pv = req_i.page_entry[`SSP_PE_VALID];
  assign lvl = req_i.vlevel;
  // combined access bits as the rule defines them
  logic [`SSP_ACC_W-1:0] acc_all;
  assign acc_all = req_i.group_entry[`SSP_GE_ACC_LSB +: `SSP_ACC_W] &
                   req_i.page_entry[`SSP_PE_ACC_LSB +: `SSP_ACC_W];

  AST_BOUND_TRAP: assert property (
    is_check && ctrl_reg[0] && gv && pv && base_valid_reg && !same_seg
    |=> res_valid_o && res_trap_o == ssp_pkg::ssp_trap_segment_bound)
    else $error("out-of-segment access not trapped");

  AST_NO_CHECK_ON_BASE: assert property (
    req_i.valid && req_i.op == ssp_pkg::ssp_op_base
    |=> res_trap_o == ssp_pkg::ssp_trap_none ##1 base_valid_reg)
    else $error("base setup raised a trap or kept no base");

  AST_INDIRECT_NEW_BASE: assert property (
    req_i.valid && req_i.op == ssp_pkg::ssp_op_indirect &&
    trap_now == ssp_pkg::ssp_trap_none
    |=> base_va_reg == $past(req_i.new_base) && base_size_reg == $past(req_i.new_size))
    else $error("indirect pointer did not become the base");

  AST_GROUP_ABSENT: assert property (
    is_check && ctrl_reg[0] && !gv
    |=> res_trap_o == ($past(req_i.in_dseg) ? ssp_pkg::ssp_trap_descriptor_absent
                                             : ssp_pkg::ssp_trap_group_absent))
    else $error("absent group not trapped");

  AST_PAGE_ABSENT: assert property (
    is_check && ctrl_reg[0] && gv && !pv
    |=> res_trap_o == ssp_pkg::ssp_trap_page_absent)
    else $error("absent page not trapped");

  AST_WRITE_RING: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    eff_kind == ssp_pkg::ssp_kind_write && lvl > req_i.group_entry[33:32]
    |=> res_trap_o == ssp_pkg::ssp_trap_permission)
    else $error("write above write ring limit allowed");

  AST_READ_RING: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    eff_kind == ssp_pkg::ssp_kind_read && lvl > req_i.group_entry[37:36]
    |=> res_trap_o == ssp_pkg::ssp_trap_permission)
    else $error("read above read ring limit allowed");

  AST_USED_SET: assert property (
    pe_upd_i.valid && pe_upd_i.entry[`SSP_PE_VALID] && ctrl_reg[1]
    |=> pe_wb_valid_o && pe_wb_o[`SSP_PE_USED] && pe_wb_o[`SSP_PE_VALID])
    else $error("used flag not set on map cache load");

  AST_MODIFIED_SET: assert property (
    pe_upd_i.valid && pe_upd_i.mark_written
    |=> pe_wb_o[`SSP_PE_MOD])
    else $error("modified flag not set on write mark");

  AST_PHYS_ADDR: assert property (
    res_valid_o |-> res_phys_o[`SSP_PA_W-1:`SSP_PAGE_BITS] ==
                    $past(req_i.page_entry[`SSP_PFN_W-1:0]))
    else $error("physical frame not on the upper address bits");

  AST_STICKY: assert property (
    res_valid_o && res_trap_o != ssp_pkg::ssp_trap_none
    |=> status_reg[$past(res_trap_o)])
    else $error("trap flag lost");

  AST_EXEC_RING: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    eff_kind == ssp_pkg::ssp_kind_fetch && lvl > req_i.group_entry[35:34]
    |=> res_trap_o == ssp_pkg::ssp_trap_permission)
    else $error("fetch above execute ring limit allowed");

  AST_XCALL_EXEMPT: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    eff_kind == ssp_pkg::ssp_kind_xcall &&
    acc_all[`SSP_ACC_EXEC] && !acc_all[`SSP_ACC_IO]
    |=> res_trap_o == ssp_pkg::ssp_trap_none)
    else $error("cross-ring call held to the execute ring limit");

  AST_ACCESS_BITS: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    ((eff_kind == ssp_pkg::ssp_kind_write && !acc_all[`SSP_ACC_WRITE]) ||
     (eff_kind == ssp_pkg::ssp_kind_fetch && !acc_all[`SSP_ACC_EXEC]) ||
     (eff_kind == ssp_pkg::ssp_kind_read && !acc_all[`SSP_ACC_READ]))
    |=> res_trap_o == ssp_pkg::ssp_trap_permission)
    else $error("access denied by the combined bits was allowed");

  AST_IO_ONLY: assert property (
    is_check && ctrl_reg[0] && gv && pv && bound_ok &&
    acc_all[`SSP_ACC_IO] && !req_i.io_instr
    |=> res_trap_o == ssp_pkg::ssp_trap_permission)
    else $error("ordinary instruction reached an io-only page");

  AST_ABSENT_FIRST: assert property (
    is_check && ctrl_reg[0] && (!gv || !pv)
    |=> res_trap_o != ssp_pkg::ssp_trap_permission &&
        res_trap_o != ssp_pkg::ssp_trap_segment_bound)
    else $error("permission or bound trap reported for an absent entry");

  AST_PAGE_OFFSET: assert property (
    res_valid_o |-> res_phys_o[`SSP_PAGE_BITS-1:0] == $past(req_i.va[`SSP_PAGE_BITS-1:0]))
    else $error("in-page bits altered");

  AST_TABLE_BASE: assert property (
    res_valid_o |-> res_pt_addr_o == {$past(req_i.group_entry[`SSP_GE_PTB_W-1:0]), 2'b00})
    else $error("page table address not formed from the group entry");

  // register bus answers after exactly one wait cycle
  AST_BUS_ONE_WAIT: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("register bus held more than one wait cycle");

  COV_BOUND: cover property (
    res_valid_o && res_trap_o == ssp_pkg::ssp_trap_segment_bound);
  COV_INDIRECT: cover property (
    req_i.valid && req_i.op == ssp_pkg::ssp_op_indirect ##1
    req_i.valid && req_i.op == ssp_pkg::ssp_op_access);
  COV_XCALL: cover property (
    is_check && eff_kind == ssp_pkg::ssp_kind_xcall && lvl > req_i.group_entry[35:34]
    ##1 res_trap_o == ssp_pkg::ssp_trap_none);
  COV_BUS_WRITE: cover property (wr_fire && reg_idx == `SSP_REG_STATUS);
endmodule

// ==== ssp_map.svh ====
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// address widths and in-page / in-group bit counts
`define SSP_VA_W 31
`define SSP_PA_W 34
`define SSP_PAGE_BITS 12
`define SSP_GROUP_BITS 4
`define SSP_SIZE_W 5
`define SSP_SIZE_MIN 5'h04
`define SSP_SIZE_MAX 5'h13

// group entry (doubleword) layout
`define SSP_GE_W 64
`define SSP_GE_VALID 63
`define SSP_GE_PTB_LSB 0
`define SSP_GE_PTB_W 32
`define SSP_GE_WR_LSB 32
`define SSP_GE_EX_LSB 34
`define SSP_GE_RD_LSB 36
`define SSP_GE_ACC_LSB 38
`define SSP_GE_SIZE_LSB 42

// page entry (singleword) layout
`define SSP_PE_W 32
`define SSP_PE_VALID 31
`define SSP_PE_USED 30
`define SSP_PE_MOD 29
`define SSP_PE_ACC_LSB 22
`define SSP_PE_PFN_LSB 0
`define SSP_PFN_W 22

// access field bits
`define SSP_ACC_W 4
`define SSP_ACC_WRITE 0
`define SSP_ACC_EXEC 1
`define SSP_ACC_READ 2
`define SSP_ACC_IO 3

// register word indices (address bits 4:2) and reset values
`define SSP_REG_CTRL 3'h0
`define SSP_REG_STATUS 3'h1
`define SSP_REG_BASE 3'h2
`define SSP_REG_TRAP 3'h3
`define SSP_REG_TRAP_VA 3'h4
`define SSP_CTRL_CHECK 0
`define SSP_CTRL_UPDATE 1
`define SSP_CTRL_RST 2'h3
`define SSP_TRAP_SIZE_LSB 8

`endif

// ==== ssp_pkg.sv ====
`include "ssp_map.svh"

package ssp_pkg;

  typedef enum logic [1:0] {
    ssp_op_base,
    ssp_op_access,
    ssp_op_indirect
  } ssp_op_t;

  typedef enum logic [1:0] {
    ssp_kind_read,
    ssp_kind_write,
    ssp_kind_fetch,
    ssp_kind_xcall
  } ssp_kind_t;

  typedef enum logic [2:0] {
    ssp_trap_none,
    ssp_trap_group_absent,
    ssp_trap_descriptor_absent,
    ssp_trap_page_absent,
    ssp_trap_segment_bound,
    ssp_trap_permission
  } ssp_trap_t;

  typedef struct packed {
    logic valid;
    ssp_op_t op;
    ssp_kind_t kind;
    logic io_instr;
    logic in_dseg;
    logic [1:0] vlevel;
    logic [`SSP_VA_W-1:0] va;
    logic [`SSP_GE_W-1:0] group_entry;
    logic [`SSP_PE_W-1:0] page_entry;
    logic [`SSP_VA_W-1:0] new_base;
    logic [`SSP_SIZE_W-1:0] new_size;
  } ssp_req_t;

  typedef struct packed {
    logic valid;
    logic mark_written;
    logic [`SSP_PE_W-1:0] entry;
  } ssp_pe_upd_t;

endpackage

// ==== ssp_seg_match.sv ====
`include "ssp_map.svh"

// same-segment test between a base address and a suspect address
module ssp_seg_match #(
  parameter int VA_W = `SSP_VA_W
) (
  input wire logic [VA_W-1:0] base_i,
  input wire logic [VA_W-1:0] addr_i,
  input wire logic [`SSP_SIZE_W-1:0] size_i,
  output logic same_o
);
  localparam int LOW = `SSP_PAGE_BITS + `SSP_GROUP_BITS;

  // the group index bits must exist above the in-group bits
  if (VA_W <= LOW || VA_W > 40) begin : g_bad_width
    $error("ssp_seg_match: VA_W out of range");
  end

  logic [VA_W-1:0] diff;

  // upper-bit compare
  // tables keep segments aligned power-of-two groups, so a mask suffices
  // size range
  for (genvar i = 0; i < VA_W; i++) begin : g_bit
    if (i < LOW) begin : g_low
      assign diff[i] = 1'b0;
    end else begin : g_up
      localparam logic [5:0] POS = 6'(i - `SSP_PAGE_BITS);
      assign diff[i] = (base_i[i] ^ addr_i[i]) & (POS >= {1'b0, size_i});
    end
  end

  assign same_o = ~|diff;
endmodule

// ==== ssp_perm_check.sv ====
`include "ssp_map.svh"

// decodes both entries and picks one trap by fixed priority
module ssp_perm_check (
  input wire logic [`SSP_GE_W-1:0] ge_i,
  input wire logic [`SSP_PE_W-1:0] pe_i,
  input wire ssp_pkg::ssp_kind_t kind_i,
  input wire logic [1:0] vlevel_i,
  input wire logic io_instr_i,
  input wire logic in_dseg_i,
  input wire logic bound_ok_i,
  output ssp_pkg::ssp_trap_t trap_o
);
  logic [1:0] wr_lim;
  logic [1:0] ex_lim;
  logic [1:0] rd_lim;
  logic [`SSP_ACC_W-1:0] acc;
  logic ring_ok;
  logic perm_ok;

  assign acc = ge_i[`SSP_GE_ACC_LSB +: `SSP_ACC_W] & pe_i[`SSP_PE_ACC_LSB +: `SSP_ACC_W];
  assign wr_lim = ge_i[`SSP_GE_WR_LSB +: 2];
  assign ex_lim = ge_i[`SSP_GE_EX_LSB +: 2];
  assign rd_lim = ge_i[`SSP_GE_RD_LSB +: 2];

  // ring limit and permission bit per kind of access
  always_comb begin
    ring_ok = 1'b1;
    perm_ok = 1'b1;
    case (kind_i)
      ssp_pkg::ssp_kind_write: begin
        ring_ok = vlevel_i <= wr_lim;
        perm_ok = acc[`SSP_ACC_WRITE];
      end
      ssp_pkg::ssp_kind_fetch: begin
        ring_ok = vlevel_i <= ex_lim;
        perm_ok = acc[`SSP_ACC_EXEC];
      end
      ssp_pkg::ssp_kind_xcall: begin
        // gated call skips the execute ring limit only
        ring_ok = 1'b1;
        perm_ok = acc[`SSP_ACC_EXEC];
      end
      default: begin
        ring_ok = vlevel_i <= rd_lim;
        perm_ok = acc[`SSP_ACC_READ];
      end
    endcase
  end

  always_comb begin
    if (!ge_i[`SSP_GE_VALID]) begin
      trap_o = in_dseg_i ? ssp_pkg::ssp_trap_descriptor_absent
                         : ssp_pkg::ssp_trap_group_absent;
    end else if (!pe_i[`SSP_PE_VALID]) begin
      trap_o = ssp_pkg::ssp_trap_page_absent;
    end else if (!bound_ok_i) begin
      trap_o = ssp_pkg::ssp_trap_segment_bound;
    end else if (!ring_ok || !perm_ok || (acc[`SSP_ACC_IO] && !io_instr_i)) begin
      trap_o = ssp_pkg::ssp_trap_permission;
    end else begin
      trap_o = ssp_pkg::ssp_trap_none;
    end
  end
endmodule

// ==== ssp_tbl_mem.sv ====
`include "ssp_map.svh"

// table memory on the far side: holds the segment layout and takes page entry write-backs
module ssp_tbl_mem #(
  parameter logic [`SSP_SIZE_W-1:0] SEG_SIZE = 5'h05,
  parameter logic [`SSP_VA_W-1:0] SEG_BASE = 31'h0004_0000
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_valid_i,
  input wire logic [`SSP_PE_W-1:0] wb_entry_i,
  output logic [`SSP_PE_W-1:0] word_o,
  output logic [7:0] wb_count_o
);
  // stored entry; a write-back replaces the whole word, as memory would
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      word_o <= 32'h0000_0000;
      wb_count_o <= 8'h00;
    end else if (wb_valid_i) begin
      word_o <= wb_entry_i;
      wb_count_o <= wb_count_o + 8'h01;
    end
  end
endmodule

// ==== testbench.sv ====
`include "ssp_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  ssp_pkg::ssp_req_t req_i = '0;
  ssp_pkg::ssp_pe_upd_t pe_upd_i = '0;
  logic res_valid_o, pe_wb_valid_o, avs_waitrequest_o;
  ssp_pkg::ssp_trap_t res_trap_o;
  logic [`SSP_PA_W-1:0] res_phys_o, res_pt_addr_o;
  logic [`SSP_PE_W-1:0] pe_wb_o, mem_word;
  logic [7:0] mem_cnt;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, rd;
  int miscompares = 0;
  int n_compared = 0;
  ssp_pkg::ssp_req_t r;
  logic [63:0] ge_ok;
  logic [31:0] pe_ok;

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  ssp_check dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .pe_upd_i(pe_upd_i),
    .res_valid_o(res_valid_o), .res_trap_o(res_trap_o), .res_phys_o(res_phys_o),
    .res_pt_addr_o(res_pt_addr_o), .pe_wb_valid_o(pe_wb_valid_o), .pe_wb_o(pe_wb_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

  ssp_tbl_mem mem (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_valid_i(pe_wb_valid_o),
    .wb_entry_i(pe_wb_o), .word_o(mem_word), .wb_count_o(mem_cnt));

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus cycle; the request stands until waitrequest is seen low
  task automatic bus(logic wr, logic [4:0] addr, logic [31:0] wdata, output logic [31:0] data);
    int n;
    @(posedge sys_clk_i);
    avs_address_i <= addr;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_writedata_i <= wdata;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    // values seen here are those sampled at this edge; the write lands on it
    data = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
  endtask

  function automatic logic [63:0] ge(logic v, logic [1:0] lim, logic [3:0] acc);
    return {v, 16'h0, mem.SEG_SIZE, acc, lim, lim, lim, 32'h0000_1230};
  endfunction

  function automatic logic [31:0] pe(logic v, logic [3:0] acc);
    return {v, 5'h00, acc, 22'h2a_5a5a};
  endfunction

  // one check request; the answer is looked at in its single result cycle
  task automatic run(string what, ssp_pkg::ssp_trap_t exp);
    @(posedge sys_clk_i);
    req_i <= r;
    @(posedge sys_clk_i);
    req_i <= '0;
    #1;
    chk({what, " valid"}, 64'(res_valid_o), 64'h1);
    chk(what, 64'(res_trap_o), 64'(exp));
  endtask

  function automatic ssp_pkg::ssp_req_t mk(ssp_pkg::ssp_op_t op, ssp_pkg::ssp_kind_t k,
    logic [1:0] vl, logic [30:0] va);
    ssp_pkg::ssp_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.op = op;
    q.kind = k;
    q.vlevel = vl;
    q.va = va;
    q.group_entry = ge_ok;
    q.page_entry = pe_ok;
    q.new_base = mem.SEG_BASE;
    q.new_size = mem.SEG_SIZE;
    return q;
  endfunction

  task automatic t_regs();
    bus(1'b0, 5'h00, 32'h0, rd);
    chk("ctrl reset", 64'(rd), 64'h3);
    bus(1'b0, 5'h04, 32'h0, rd);
    chk("status reset", 64'(rd), 64'h0);
    bus(1'b0, 5'h14, 32'h0, rd);
    chk("unmapped", 64'(rd), 64'h0);
  endtask

  task automatic t_bounds();
    r = mk(ssp_pkg::ssp_op_base, ssp_pkg::ssp_kind_read, 2'h0, 31'h0);
    run("base", ssp_pkg::ssp_trap_none);
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h0, 31'h0005_f234);
    run("inside", ssp_pkg::ssp_trap_none);
    chk("phys", 64'(res_phys_o), {30'h0, 22'h2a_5a5a, 12'h234});
    chk("pt addr", 64'(res_pt_addr_o), {30'h0, 32'h0000_1230, 2'b00});
    r.va = 31'h0006_0000;
    run("above", ssp_pkg::ssp_trap_segment_bound);
    r.va = 31'h0003_ffff;
    run("below", ssp_pkg::ssp_trap_segment_bound);
  endtask

  task automatic t_rings();
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h3, 31'h0004_0010);
    run("read ring", ssp_pkg::ssp_trap_permission);
    r.vlevel = 2'h2;
    run("read at limit", ssp_pkg::ssp_trap_none);
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_write, 2'h3, 31'h0004_0010);
    run("write ring", ssp_pkg::ssp_trap_permission);
    r.kind = ssp_pkg::ssp_kind_fetch;
    run("fetch ring", ssp_pkg::ssp_trap_permission);
    r.kind = ssp_pkg::ssp_kind_xcall;
    run("xcall", ssp_pkg::ssp_trap_none);
  endtask

  // each kind is refused once its own access bit is cleared in the page entry
  task automatic t_access();
    ssp_pkg::ssp_kind_t k[3] = '{ssp_pkg::ssp_kind_write, ssp_pkg::ssp_kind_fetch,
      ssp_pkg::ssp_kind_read};
    for (int i = 0; i < 3; i++) begin
      r = mk(ssp_pkg::ssp_op_access, k[i], 2'h0, 31'h0004_0020);
      r.page_entry = pe(1'b1, 4'h7 & ~(4'h1 << i));
      run("acc and", ssp_pkg::ssp_trap_permission);
      r.group_entry = ge(1'b1, 2'h2, 4'h7 & ~(4'h1 << i));
      r.page_entry = pe_ok;
      run("acc group", ssp_pkg::ssp_trap_permission);
    end
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h0, 31'h0004_0020);
    r.group_entry = ge(1'b1, 2'h2, 4'hf);
    r.page_entry = pe(1'b1, 4'hf);
    run("io plain", ssp_pkg::ssp_trap_permission);
    r.io_instr = 1'b1;
    run("io ok", ssp_pkg::ssp_trap_none);
    r.page_entry = pe(1'b1, 4'hb);
    run("io noread", ssp_pkg::ssp_trap_permission);
  endtask

  task automatic t_absent();
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h3, 31'h0004_0020);
    r.group_entry = ge(1'b0, 2'h2, 4'h7);
    run("group", ssp_pkg::ssp_trap_group_absent);
    r.in_dseg = 1'b1;
    run("dseg", ssp_pkg::ssp_trap_descriptor_absent);
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h3, 31'h0004_0020);
    r.page_entry = pe(1'b0, 4'h7);
    run("page", ssp_pkg::ssp_trap_page_absent);
  endtask

  task automatic t_indirect();
    r = mk(ssp_pkg::ssp_op_indirect, ssp_pkg::ssp_kind_read, 2'h0, 31'h0005_1000);
    r.new_base = 31'h0020_0000;
    r.new_size = 5'h04;
    run("indirect", ssp_pkg::ssp_trap_none);
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h0, 31'h0020_fabc);
    run("new seg", ssp_pkg::ssp_trap_none);
    r.va = 31'h0005_1000;
    run("old seg", ssp_pkg::ssp_trap_segment_bound);
  endtask

  task automatic upd(logic [31:0] e, logic m, logic ev, logic [31:0] ee);
    @(posedge sys_clk_i);
    pe_upd_i <= '{valid: 1'b1, mark_written: m, entry: e};
    @(posedge sys_clk_i);
    pe_upd_i <= '0;
    #1;
    chk("wb valid", 64'(pe_wb_valid_o), 64'(ev));
    if (ev) chk("wb entry", 64'(pe_wb_o), 64'(ee));
  endtask

  task automatic t_update();
    upd(pe(1'b1, 4'h5), 1'b0, 1'b1, pe(1'b1, 4'h5) | 32'h4000_0000);
    upd(pe(1'b1, 4'h5), 1'b1, 1'b1, pe(1'b1, 4'h5) | 32'h6000_0000);
    upd(pe(1'b0, 4'h5), 1'b1, 1'b0, 32'h0);
    @(posedge sys_clk_i);
    chk("mem word", 64'(mem_word), 64'(pe(1'b1, 4'h5) | 32'h6000_0000));
    chk("mem count", 64'(mem_cnt), 64'h2);
  endtask

  task automatic t_status();
    bus(1'b0, 5'h04, 32'h0, rd);
    chk("status", 64'(rd), 64'h3e);
    bus(1'b1, 5'h04, 32'h3e, rd);
    bus(1'b0, 5'h04, 32'h0, rd);
    chk("status clr", 64'(rd), 64'h0);
    bus(1'b0, 5'h08, 32'h0, rd);
    chk("base reg", 64'(rd), 64'h8020_0000);
    bus(1'b0, 5'h0c, 32'h0, rd);
    chk("trap reg", 64'(rd), 64'h404);
    bus(1'b0, 5'h10, 32'h0, rd);
    chk("trap va", 64'(rd), 64'h0005_1000);
    // both control bits off: no trap and no write-back, then restore
    bus(1'b1, 5'h00, 32'h0, rd);
    r = mk(ssp_pkg::ssp_op_access, ssp_pkg::ssp_kind_read, 2'h3, 31'h0005_1000);
    run("check off", ssp_pkg::ssp_trap_none);
    upd(pe(1'b1, 4'h5), 1'b1, 1'b0, 32'h0);
    bus(1'b1, 5'h00, 32'h3, rd);
  endtask

  initial begin
    ge_ok = ge(1'b1, 2'h2, 4'h7);
    pe_ok = pe(1'b1, 4'h7);
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_bounds();
    t_rings();
    t_access();
    t_absent();
    t_indirect();
    t_update();
    t_status();
    print_verdict();
  end
endmodule
